// File: flash_program_erase_control.sv
// Design decisions made here: the address map and register access over AXI4-Lite.
`timescale 1ns/1ps
// How it works
// - erase never clears less than one 64-byte page
// - one programming cycle accepts at most one 32-byte row
// - erased cells read one, programmed cells read zero
// - high voltage sets only with program or erase selected and steps done
// - high voltage bit drives charge pump and array high voltage
// - mass bit selects whole-array erase, else page erase
// - erase and program select can never both be one
// - page erase clears the aligned page holding the latched address
// - the 48-byte vector region erases as its own page
// - hv request refused while erase and mass bits are already set unless protect value is all ones
// - programmed bytes must all lie in the latched 32-byte row
// - program select latches address and data of array writes
// - vector page erase also clears the oscillator trim byte
// - protected addresses block setting high voltage
// - protect bits are start address bits 13 to 6
// - all zeros protects from c000 up, all ones protects nothing
module flash_program_erase_control
  import fpec_pkg::*;
#(
  parameter int unsigned DEPTH = 16384
) (
  input  wire logic          clk,            // 40 mhz system clock
  input  wire logic          rst_n,          // sync reset, active low
  input  wire logic [7:0]    s_axi_awaddr,   // write address
  input  wire logic          s_axi_awvalid,  // write address valid
  output logic               s_axi_awready,  // write address ready
  input  wire logic [31:0]   s_axi_wdata,    // write data
  input  wire logic [3:0]    s_axi_wstrb,    // write strobes
  input  wire logic          s_axi_wvalid,   // write data valid
  output logic               s_axi_wready,   // write data ready
  output logic [1:0]         s_axi_bresp,    // write response
  output logic               s_axi_bvalid,   // write response valid
  input  wire logic          s_axi_bready,   // write response ready
  input  wire logic [7:0]    s_axi_araddr,   // read address
  input  wire logic          s_axi_arvalid,  // read address valid
  output logic               s_axi_arready,  // read address ready
  output logic [31:0]        s_axi_rdata,    // read data
  output logic [1:0]         s_axi_rresp,    // read response
  output logic               s_axi_rvalid,   // read data valid
  input  wire logic          s_axi_rready,   // read data ready
  output logic               charge_pump_on, // charge pump enable
  output logic               array_hv_on     // high voltage routed to array
);
  fpec_ctrl_t    ctrl;
  fpec_state_t   state;
  logic [7:0]    block_protect_value;
  logic [15:0]   flash_addr;
  logic [15:0]   latch_addr;
  logic [7:0]    latch_data;
  logic [15:0]   row_addr;
  logic [7:0]    arr_rd;
  logic          aw_held, w_held;
  logic [7:0]    aw_q;
  logic [31:0]   w_q;
  logic [3:0]    ws_q;
  logic          wr_go, rd_go;
  logic          wr_ctl, wr_prot, wr_adr, wr_dat;
  logic          rd_prot;
  logic          erase_pulse, prog_pulse;
  logic          refused;
  logic [15:0]   prot_start;
  logic          addr_protected;
  logic          mass_ok;
  logic          hv_allowed;
  logic [7:0]    wctl;
  logic          next_hv;
  logic [31:0]   next_rdata;
  logic [1:0]    next_rresp;
  logic [1:0]    next_bresp;
  logic [15:0]   arr_op_addr;

  assign prot_start     = {PROT_TOP, block_protect_value, 6'h00};
  assign addr_protected = (block_protect_value != PROTECT_OPEN) && (latch_addr >= prot_start);
  // mass erase only when nothing protected
  assign mass_ok        = (block_protect_value == PROTECT_OPEN);
  // a write runs once both halves are held and the last response has gone
  assign wr_go  = aw_held && w_held && !s_axi_bvalid;
  assign rd_go  = s_axi_arvalid && s_axi_arready;
  assign wr_ctl = wr_go && (aw_q == OFS_CONTROL) && ws_q[0];
  assign wr_prot = wr_go && (aw_q == OFS_PROTECT) && ws_q[0];
  assign wr_adr = wr_go && (aw_q == OFS_ADDRESS);
  assign wr_dat = wr_go && (aw_q == OFS_DATA) && ws_q[0];
  assign rd_prot = rd_go && (s_axi_araddr == OFS_PROTECT);
  assign wctl   = w_q[7:0];

  // write channel capture, address and data in either order
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      aw_q    <= 8'h00;
      w_q     <= 32'h0;
      ws_q    <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_q    <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_q    <= s_axi_wdata;
        ws_q   <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      // ready drops right after a handshake so one beat is never taken twice
      s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
      s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= next_bresp;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // write response: status writes are ignored, unknown offsets refused
  always_comb begin
    next_bresp = RESP_SLVERR;
    if (aw_q == OFS_CONTROL || aw_q == OFS_PROTECT || aw_q == OFS_ADDRESS) begin
      next_bresp = RESP_OKAY;
    end else if (aw_q == OFS_DATA) begin
      next_bresp = refused ? RESP_SLVERR : RESP_OKAY;
    end else if (aw_q == OFS_STATUS) begin
      next_bresp = RESP_OKAY;
    end
  end

  // array write to address (step 3) or data while programming
  always_comb begin
    refused = 1'b0;
    if (wr_dat && state == FPEC_HV_ON && ctrl.program_select) begin
      // byte must stay in latched row
      // a refused byte leaves the array alone and answers with an error
      refused = (flash_addr[15:ROW_LSB] != row_addr[15:ROW_LSB]);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      flash_addr <= 16'h0000;
    end else if (wr_adr) begin
      flash_addr <= w_q[15:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      block_protect_value <= PROTECT_RESET;
    end else if (wr_prot && ctrl.hv && ctrl.program_select && mass_ok) begin
      // the protect byte only loses bits, and only inside a program cycle
      block_protect_value <= block_protect_value & w_q[7:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= FPEC_IDLE;
      latch_addr <= 16'h0000;
      latch_data <= 8'h00;
      row_addr   <= 16'h0000;
    end else begin
      case (state)
        FPEC_IDLE: begin
          if (ctrl.program_select || ctrl.ers) begin
            state <= FPEC_SELECTED;
          end
        end
        FPEC_SELECTED: begin
          if (!ctrl.program_select && !ctrl.ers) begin
            state <= FPEC_IDLE;
          end else if (rd_prot) begin
            state <= FPEC_PROT_READ;
          end
        end
        FPEC_PROT_READ: begin
          if (!ctrl.program_select && !ctrl.ers) begin
            state <= FPEC_IDLE;
          end else if (wr_dat || wr_prot) begin
            state      <= FPEC_LATCHED;
            latch_addr <= wr_prot ? {PROT_TOP, 14'h3fbe} : flash_addr;
            row_addr   <= flash_addr;
            latch_data <= w_q[7:0];
          end
        end
        FPEC_LATCHED: begin
          if (!ctrl.program_select && !ctrl.ers) begin
            state <= FPEC_IDLE;
          end else if (next_hv) begin
            state <= FPEC_HV_ON;
          end
        end
        FPEC_HV_ON: begin
          if (!ctrl.program_select && !ctrl.ers) begin
            state <= FPEC_HV_HOLD;
          // each accepted byte is kept for the status word
          end else if (wr_dat && !refused) begin
            latch_data <= w_q[7:0];
          end
        end
        FPEC_HV_HOLD: begin
          // select already dropped; wait for software to remove high voltage
          if (!ctrl.hv) begin
            state <= FPEC_IDLE;
          end
        end
        default: state <= FPEC_IDLE;
      endcase
    end
  end

  // gate on the high voltage request
  always_comb begin
    hv_allowed = (state == FPEC_LATCHED) && (ctrl.program_select || ctrl.ers) && !addr_protected;
    if (ctrl.ers && ctrl.mass && !mass_ok) begin
      hv_allowed = 1'b0;
    end
    // an ignored request leaves the bit clear and still answers okay
    next_hv = wr_ctl && wctl[BIT_HV] && !ctrl.hv && hv_allowed;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ctrl <= fpec_ctrl_t'(CONTROL_RESET[3:0]);
    end else if (wr_ctl) begin
      // interlock: refuse setting a select while the other is one or both at once
      if (!(wctl[BIT_PGM] && wctl[BIT_ERS])) begin
        ctrl.program_select <= wctl[BIT_PGM] && !ctrl.ers;
        ctrl.ers <= wctl[BIT_ERS] && !ctrl.program_select;
      end else begin
        ctrl.program_select <= 1'b0;
        ctrl.ers <= 1'b0;
      end
      ctrl.mass <= wctl[BIT_MASS];
      // hv stays until software clears it
      if (!wctl[BIT_HV]) begin
        ctrl.hv <= 1'b0;
      end else if (next_hv) begin
        ctrl.hv <= 1'b1;
      end
    end
  end

  // pump and array high voltage follow the bit
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      charge_pump_on <= 1'b0;
      array_hv_on    <= 1'b0;
    end else begin
      charge_pump_on <= ctrl.hv;
      array_hv_on    <= ctrl.hv;
    end
  end

  // erase fires once when erase select drops with hv on; program once per byte
  assign erase_pulse = (state == FPEC_HV_ON) && ctrl.ers && wr_ctl && !wctl[BIT_ERS];
  assign prog_pulse  = (state == FPEC_HV_ON) && ctrl.program_select && wr_dat && !refused;
  // a program pulse targets the byte written, an erase the latched address
  assign arr_op_addr = prog_pulse ? flash_addr : latch_addr;

  fpec_array #(
    .DEPTH (DEPTH)
  ) u_array (
    .clk      (clk),
    .rst_n    (rst_n),
    .hv_on    (ctrl.hv),
    .do_erase (erase_pulse),
    .do_mass  (ctrl.mass),
    .do_prog  (prog_pulse),
    .op_addr  (arr_op_addr),
    .op_data  (w_q[7:0]),
    .rd_addr  (flash_addr),
    .rd_data  (arr_rd)
  );

  // read word for the offset on the read address channel
  always_comb begin
    next_rdata = 32'h0;
    next_rresp = RESP_OKAY;
    if (s_axi_araddr == OFS_CONTROL) begin
      next_rdata = {28'h0, ctrl.hv, ctrl.mass, ctrl.ers, ctrl.program_select};
    end else if (s_axi_araddr == OFS_PROTECT) begin
      next_rdata = {24'h0, block_protect_value};
    end else if (s_axi_araddr == OFS_ADDRESS) begin
      next_rdata = {16'h0, flash_addr};
    end else if (s_axi_araddr == OFS_DATA) begin
      next_rdata = {24'h0, arr_rd};
    end else if (s_axi_araddr == OFS_STATUS) begin
      // protect hit, sequence step, low bits of the last data byte
      next_rdata = {21'h0, addr_protected, state, latch_data[6:0]};
    end else begin
      next_rresp = RESP_SLVERR;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      // one read in flight: ready returns once the data has been taken
      s_axi_arready <= !s_axi_rvalid && !rd_go;
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= next_rresp;
        s_axi_rdata  <= next_rdata;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : flash_program_erase_control

// File: fpec_array.sv
`timescale 1ns/1ps
module fpec_array
  import fpec_pkg::*;
#(
  parameter int unsigned DEPTH = 16384
) (
  input  wire logic          clk,         // system clock
  input  wire logic          rst_n,       // sync reset
  input  wire logic          hv_on,       // high voltage on array
  input  wire logic          do_erase,    // erase pulse
  input  wire logic          do_mass,     // whole array erase
  input  wire logic          do_prog,     // program pulse
  input  wire logic [15:0]   op_addr,     // target address
  input  wire logic [7:0]    op_data,     // program data
  input  wire logic [15:0]   rd_addr,     // read address
  output logic      [7:0]    rd_data      // read data
);
  localparam int unsigned AW = $clog2(DEPTH);
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] base;
  logic [AW-1:0] rix;
  logic          in_vec;

  // array is indexed by the low AW address bits, so it repeats through the address map
  assign base   = op_addr[AW-1:0];
  assign rix    = rd_addr[AW-1:0];
  assign in_vec = (op_addr >= VECTOR_PAGE);

  always_ff @(posedge clk) begin
    if (hv_on && do_erase) begin
      for (int i = 0; i < DEPTH; i++) begin
        if (do_mass) begin
          mem[i] <= ERASED_BYTE;
        end else if (in_vec && (AW'(i) >= AW'(VECTOR_PAGE))) begin
          mem[i] <= ERASED_BYTE;
        end else if (!in_vec && (AW'(i) >> PAGE_LSB) == (base >> PAGE_LSB)) begin
          mem[i] <= ERASED_BYTE;
        end
      end
    end else if (hv_on && do_prog) begin
      mem[base] <= mem[base] & op_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rix];
    end
  end
endmodule : fpec_array

// File: fpec_cpu.sv
`timescale 1ns/1ps
module fpec_cpu (
  input  wire logic        clk,             // clock
  output logic [7:0]       awaddr  = 8'h00, // aw addr
  output logic             awvalid = 1'b0,  // aw valid
  input  wire logic        awready,         // aw ready
  output logic [31:0]      wdata   = 32'h0, // w data
  output logic             wvalid  = 1'b0,  // w valid
  input  wire logic        wready,          // w ready
  input  wire logic [1:0]  bresp,           // b resp
  input  wire logic        bvalid,          // b valid
  output logic             bready  = 1'b0,  // b ready
  output logic [7:0]       araddr  = 8'h00, // ar addr
  output logic             arvalid = 1'b0,  // ar valid
  input  wire logic        arready,         // ar ready
  input  wire logic [31:0] rdata,           // r data
  input  wire logic [1:0]  rresp,           // r resp
  input  wire logic        rvalid,          // r valid
  output logic             rready  = 1'b0   // r ready
);
  logic [1:0]  x;
  logic [31:0] y;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 99 && (awvalid || wvalid || !bvalid); n++) begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end
    if (n >= 99) tb_top.stop_test(1'b1);
    // late bready lets the response wait
    bready <= 1'b1;
    @(posedge clk);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 99 && (arvalid || !rvalid); n++) begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end
    if (n >= 99) tb_top.stop_test(1'b1);
    rready <= 1'b1;
    @(posedge clk);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
  // row program order, watchdog address never used
  task automatic prog(input logic [15:0] la, input logic [15:0] a, input logic [7:0] d,
                      output logic [1:0] r);
    wr(8'h00, 32'h1, x);
    rd(8'h04, y, x);
    wr(8'h08, {16'h0, la}, x);
    wr(8'h0c, 32'hff, x);
    wr(8'h00, 32'h9, x);
    wr(8'h08, {16'h0, a}, x);
    wr(8'h0c, {24'h0, d}, r);
    wr(8'h00, 32'h8, x);
    wr(8'h00, 32'h0, x);
  endtask : prog
  // erase order; monitor mode sends the trigger to the protect location
  task automatic erase(input logic mass, input logic mon, input logic [15:0] a);
    wr(8'h00, mass ? 32'h6 : 32'h2, x);
    rd(8'h04, y, x);
    wr(8'h08, {16'h0, a}, x);
    wr(mon ? 8'h04 : 8'h0c, 32'h0, x);
    wr(8'h00, mass ? 32'he : 32'ha, x);
    wr(8'h00, 32'h8, x);
    wr(8'h00, 32'h0, x);
  endtask : erase
  task automatic peek(input logic [15:0] a, output logic [7:0] d);
    wr(8'h08, {16'h0, a}, x);
    rd(8'h0c, y, x);
    d = y[7:0];
  endtask : peek
  // protect byte written like an array byte inside a program cycle
  task automatic protect(input logic [7:0] v);
    wr(8'h00, 32'h1, x);
    rd(8'h04, y, x);
    wr(8'h08, 32'h0, x);
    wr(8'h0c, 32'hff, x);
    wr(8'h00, 32'h9, x);
    wr(8'h04, {24'h0, v}, x);
    wr(8'h00, 32'h8, x);
    wr(8'h00, 32'h0, x);
  endtask : protect
endmodule : fpec_cpu

// File: fpec_pkg.sv
package fpec_pkg;
  localparam int unsigned ADDR_W = 16;
  // register byte addresses on the axi4-lite slave
  localparam logic [7:0] OFS_CONTROL  = 8'h00;
  localparam logic [7:0] OFS_PROTECT  = 8'h04;
  localparam logic [7:0] OFS_ADDRESS  = 8'h08;
  localparam logic [7:0] OFS_DATA     = 8'h0c;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  // flash_control field positions
  localparam int unsigned BIT_PGM  = 0;
  localparam int unsigned BIT_ERS  = 1;
  localparam int unsigned BIT_MASS = 2;
  localparam int unsigned BIT_HV   = 3;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] PROTECT_OPEN  = 8'hff;
  localparam logic [7:0] PROTECT_RESET = 8'hff;
  // array geometry
  localparam int unsigned PAGE_BYTES = 64;
  localparam int unsigned ROW_BYTES  = 32;
  localparam int unsigned PAGE_LSB   = 6;
  localparam int unsigned ROW_LSB    = 5;
  localparam logic [15:0] VECTOR_BASE = 16'hffd0;
  localparam logic [15:0] VECTOR_PAGE = 16'hffc0;
  localparam logic [15:0] TRIM_ADDR   = 16'hffc0;
  localparam logic [1:0]  PROT_TOP    = 2'b11;
  localparam logic [1:0]  RESP_OKAY   = 2'b00;
  localparam logic [1:0]  RESP_SLVERR = 2'b10;
  localparam logic [7:0]  ERASED_BYTE = 8'hff;

  typedef enum logic [2:0] {
    FPEC_IDLE, FPEC_SELECTED, FPEC_PROT_READ, FPEC_LATCHED, FPEC_HV_ON, FPEC_HV_HOLD
  } fpec_state_t;

  typedef struct packed {
    logic        program_select;
    logic        ers;
    logic        mass;
    logic        hv;
  } fpec_ctrl_t;

  typedef struct packed {
    logic        we;
    logic [15:0] addr;
    logic [7:0]  data;
  } fpec_arr_req_t;
endpackage : fpec_pkg

// File: fpec_sva.sv
`timescale 1ns/1ps
module fpec_sva
  import fpec_pkg::*;
(
  input wire logic        clk,            // clock
  input wire logic        rst_n,          // reset
  input wire logic        s_axi_awvalid,  // aw valid
  input wire logic        s_axi_awready,  // aw ready
  input wire logic        s_axi_wvalid,   // w valid
  input wire logic        s_axi_wready,   // w ready
  input wire logic [1:0]  s_axi_bresp,    // b resp
  input wire logic        s_axi_bvalid,   // b valid
  input wire logic        s_axi_bready,   // b ready
  input wire logic [7:0]  s_axi_araddr,   // ar addr
  input wire logic        s_axi_arvalid,  // ar valid
  input wire logic        s_axi_arready,  // ar ready
  input wire logic [31:0] s_axi_rdata,    // r data
  input wire logic [1:0]  s_axi_rresp,    // r resp
  input wire logic        s_axi_rvalid,   // r valid
  input wire logic        charge_pump_on, // pump on
  input wire logic        array_hv_on     // array hv
);
  logic [3:0] since_w;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // cycles since write data was last taken
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      since_w <= 4'hf;
    end else if (s_axi_wvalid && s_axi_wready) begin
      since_w <= 4'h0;
    end else if (since_w != 4'hf) begin
      since_w <= since_w + 4'h1;
    end
  end
  AST_PUMP_PAIR: assert property (charge_pump_on == array_hv_on)
    else $error("pump and array hv differ");
  AST_RESET_QUIET: assert property ($rose(rst_n) |-> !charge_pump_on && !s_axi_bvalid)
    else $error("outputs busy after reset");
  AST_HV_RISE: assert property ($rose(charge_pump_on) |-> since_w < 4'h8)
    else $error("pump rose without a write");
  AST_HV_FALL: assert property ($fell(charge_pump_on) |-> since_w < 4'h8)
    else $error("pump fell without a write");
  AST_BVALID_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  AST_BRESP_TIME: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
    s_axi_wready |-> ##[1:3] s_axi_bvalid)
    else $error("write response late");
  AST_RVALID_TIME: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read data late");
  AST_UNMAPPED: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h20
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  COV_PUMP: cover property ($rose(charge_pump_on));
  COV_WR_ERR: cover property (s_axi_bvalid && s_axi_bresp == RESP_SLVERR);
  COV_RD_ERR: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : fpec_sva

// File: tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import fpec_pkg::*;
  logic        clk, rst_n, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, pump, hv;
  logic [1:0]  bresp, rresp, r2;
  logic [7:0]  awaddr, araddr, b8;
  logic [7:0]  dv[5];
  logic [15:0] ad[5];
  logic [31:0] wdata, rdata, d32;
  int          seed, n_fail, checks_done, i;
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  fpec_cpu cpu (.clk(clk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready));
  flash_program_erase_control #(.DEPTH(1024)) dut (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .charge_pump_on(pump), .array_hv_on(hv));
  function automatic logic [7:0] programmed(input logic [7:0] old, input logic [7:0] d);
    return old & d;
  endfunction : programmed
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic stop_test(input bit hung);
    if (hung) $display("[FAIL] %0t wait limit reached", $time);
    n_fail += hung;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  initial begin
    seed = 56;
    n_fail = 0;
    checks_done = 0;
    rst_n = 1'b0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    cpu.rd(OFS_CONTROL, d32, r2);
    check(d32[7:0], CONTROL_RESET);
    cpu.rd(OFS_PROTECT, d32, r2);
    check(d32[7:0], PROTECT_RESET);
    cpu.rd(8'h20, d32, r2);
    check({6'h0, r2}, {6'h0, RESP_SLVERR});
    $display("test reset and unmapped done");
    cpu.wr(OFS_CONTROL, 32'h3, r2);
    cpu.rd(OFS_CONTROL, d32, r2);
    check(d32[7:0], 8'h00);
    cpu.wr(OFS_CONTROL, 32'h8, r2);
    cpu.rd(OFS_CONTROL, d32, r2);
    check(d32[7:0], 8'h00);
    cpu.wr(OFS_CONTROL, 32'h1, r2);
    cpu.wr(OFS_CONTROL, 32'h9, r2);
    cpu.rd(OFS_CONTROL, d32, r2);
    check(d32[7:0], 8'h01);
    check({7'h0, pump}, 8'h00);
    cpu.wr(OFS_CONTROL, 32'h0, r2);
    $display("test order and interlock done");
    cpu.erase(1'b1, 1'b0, 16'h0123);
    for (i = 0; i < 3; i++) begin
      cpu.peek(16'($random(seed)), b8);
      check(b8, ERASED_BYTE);
    end
    ad = '{16'h0040 + 16'($random(seed) & 31), 16'h007f, 16'h0080, 16'h0060, TRIM_ADDR};
    for (i = 0; i < 5; i++) dv[i] = programmed(ERASED_BYTE, 8'($random(seed)) & 8'h7f);
    dv[3] = ERASED_BYTE;
    for (i = 0; i < 3; i++) cpu.prog(ad[i], ad[i], dv[i], r2);
    cpu.prog(16'h0040, ad[3], 8'h00, r2);
    check({6'h0, r2}, {6'h0, RESP_SLVERR});
    for (i = 0; i < 4; i++) begin
      cpu.peek(ad[i], b8);
      check(b8, dv[i]);
    end
    $display("test program done");
    cpu.erase(1'b0, 1'b0, 16'h0050);
    dv[0] = ERASED_BYTE;
    dv[1] = ERASED_BYTE;
    for (i = 0; i < 4; i++) begin
      cpu.peek(ad[i], b8);
      check(b8, dv[i]);
    end
    $display("test page erase done");
    cpu.prog(ad[4], ad[4], dv[4], r2);
    cpu.peek(ad[4], b8);
    check(b8, dv[4]);
    cpu.erase(1'b0, 1'b0, 16'hffd8);
    cpu.peek(ad[4], b8);
    check(b8, ERASED_BYTE);
    $display("test vector page done");
    cpu.erase(1'b1, 1'b1, 16'h0000);
    cpu.peek(ad[2], b8);
    check(b8, ERASED_BYTE);
    $display("test monitor mass erase done");
    cpu.prog(16'h0100, 16'h0100, 8'h5a, r2);
    cpu.protect(8'hfe);
    cpu.rd(OFS_PROTECT, d32, r2);
    check(d32[7:0], programmed(PROTECT_RESET, 8'hfe));
    cpu.prog(16'hff60, 16'hff60, 8'h3c, r2);
    cpu.prog(16'hffa0, 16'hffa0, 8'h00, r2);
    cpu.peek(16'hff60, b8);
    check(b8, programmed(ERASED_BYTE, 8'h3c));
    cpu.peek(16'hffa0, b8);
    check(b8, ERASED_BYTE);
    check({7'h0, pump}, 8'h00);
    cpu.erase(1'b1, 1'b0, 16'h0100);
    cpu.peek(16'h0100, b8);
    check(b8, programmed(ERASED_BYTE, 8'h5a));
    $display("test protection done");
    stop_test(1'b0);
  end
endmodule : tb_top
bind flash_program_erase_control fpec_sva u_sva (.*);
